// [hw/mpgf_filter.v]
// Our own choice: strobed register access.
`include "mpgf_consts.vh"
module mpgf_filter (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [11:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  input wire i_vbus_valid,
  input wire [63:0] i_vbus_addr,
  input wire i_vbus_from_this_port,
  output reg o_egress_valid,
  output reg o_egress_mcast,
  output reg [63:0] o_egress_addr,
  input wire i_ingress_valid,
  input wire [63:0] i_ingress_addr,
  output reg o_ingress_valid,
  output reg o_ingress_drop,
  output reg o_ingress_mcast,
  output reg [5:0] o_ingress_group
);
  localparam GRP_W = 6;
  localparam NUM_GRP = 64;
  localparam [6:0] GRP_SPAN = 7'h06;

  // Register state
  reg [15:0] ctl_ff;
  reg [31:0] base_lo_ff;
  reg [31:0] base_hi_ff;
  reg [31:0] egr_lo_ff;
  reg [31:0] egr_hi_ff;
  reg [31:0] blk_lo_ff;

  // Register port decode
  reg sel_ctl;
  reg sel_base_lo;
  reg sel_base_hi;
  reg sel_egr_lo;
  reg sel_egr_hi;
  reg sel_blk_lo;
  reg [31:0] nxt_rdata;
  wire [15:0] nxt_ctl;
  wire [31:0] nxt_base_lo;

  // Control and window fields
  wire mcast_en;
  wire [GRP_W-1:0] num_group;
  wire [GRP_W-1:0] index_pos;
  wire [63:0] base_addr;
  wire [63:0] egr_mask;
  wire [63:0] blk_mask;
  wire [6:0] win_shift;

  // Per-group qualifiers
  wire [NUM_GRP-1:0] grp_en;
  wire [NUM_GRP-1:0] egr_pass;
  wire [NUM_GRP-1:0] blk_hit;

  // Egress classification
  wire eg_above_base;
  wire [63:0] eg_off;
  wire [63:0] eg_span;
  wire eg_in_win;
  wire [63:0] eg_sh;
  wire [GRP_W-1:0] eg_grp;
  wire eg_mcast;
  wire eg_forward;
  wire nxt_egress_valid;

  // Ingress classification
  wire in_above_base;
  wire [63:0] in_off;
  wire [63:0] in_span;
  wire in_in_win;
  wire [63:0] in_sh;
  wire [GRP_W-1:0] in_grp;
  wire in_mcast;
  wire nxt_ingress_drop;

  // One select per mapped offset; unmapped offsets select nothing
  always @* begin
    sel_ctl = 1'b0;
    sel_base_lo = 1'b0;
    sel_base_hi = 1'b0;
    sel_egr_lo = 1'b0;
    sel_egr_hi = 1'b0;
    sel_blk_lo = 1'b0;
    if (i_reg_addr == `MPGF_OFS_CTL) begin
      sel_ctl = 1'b1;
    end else if (i_reg_addr == `MPGF_OFS_BASE_LO) begin
      sel_base_lo = 1'b1;
    end else if (i_reg_addr == `MPGF_OFS_BASE_HI) begin
      sel_base_hi = 1'b1;
    end else if (i_reg_addr == `MPGF_OFS_EGR_LO) begin
      sel_egr_lo = 1'b1;
    end else if (i_reg_addr == `MPGF_OFS_EGR_HI) begin
      sel_egr_hi = 1'b1;
    end else if (i_reg_addr == `MPGF_OFS_BLK_LO) begin
      sel_blk_lo = 1'b1;
    end
  end

  // Reserved bits are stored as zero so they read back as zero
  assign nxt_ctl = {i_reg_wdata[`MPGF_CTL_EN_BIT], 9'h000,
                    i_reg_wdata[`MPGF_FLD_MSB:`MPGF_FLD_LSB]};
  assign nxt_base_lo = {i_reg_wdata[31:`MPGF_BASE_LO_LSB], 6'h00,
                        i_reg_wdata[`MPGF_FLD_MSB:`MPGF_FLD_LSB]};

  // Each register has its own write enable
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_ff <= `MPGF_RST_CTL;
    end else if (i_reg_wr && sel_ctl) begin
      ctl_ff <= nxt_ctl;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_lo_ff <= `MPGF_RST_WORD;
    end else if (i_reg_wr && sel_base_lo) begin
      base_lo_ff <= nxt_base_lo;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_hi_ff <= `MPGF_RST_WORD;
    end else if (i_reg_wr && sel_base_hi) begin
      base_hi_ff <= i_reg_wdata;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      egr_lo_ff <= `MPGF_RST_WORD;
    end else if (i_reg_wr && sel_egr_lo) begin
      egr_lo_ff <= i_reg_wdata;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      egr_hi_ff <= `MPGF_RST_WORD;
    end else if (i_reg_wr && sel_egr_hi) begin
      egr_hi_ff <= i_reg_wdata;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      blk_lo_ff <= `MPGF_RST_WORD;
    end else if (i_reg_wr && sel_blk_lo) begin
      blk_lo_ff <= i_reg_wdata;
    end
  end

  // Unmapped offsets read as zero
  always @* begin
    nxt_rdata = `MPGF_RST_WORD;
    if (sel_ctl) begin
      nxt_rdata = {16'h0000, ctl_ff};
    end else if (sel_base_lo) begin
      nxt_rdata = base_lo_ff;
    end else if (sel_base_hi) begin
      nxt_rdata = base_hi_ff;
    end else if (sel_egr_lo) begin
      nxt_rdata = egr_lo_ff;
    end else if (sel_egr_hi) begin
      nxt_rdata = egr_hi_ff;
    end else if (sel_blk_lo) begin
      nxt_rdata = blk_lo_ff;
    end
  end

  // Read data stand only in the cycle after the read strobe
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= `MPGF_RST_WORD;
    end else begin
      o_reg_rdata <= i_reg_rd ? nxt_rdata : `MPGF_RST_WORD;
    end
  end

  assign mcast_en = ctl_ff[`MPGF_CTL_EN_BIT];
  assign num_group = ctl_ff[`MPGF_FLD_MSB:`MPGF_FLD_LSB];
  assign index_pos = base_lo_ff[`MPGF_FLD_MSB:`MPGF_FLD_LSB];
  assign base_addr = {base_hi_ff, base_lo_ff[31:`MPGF_BASE_LO_LSB],
                      12'h000};
  assign egr_mask = {egr_hi_ff, egr_lo_ff};
  // Upper block-all half is not built, so groups 32 to 63 never block
  assign blk_mask = {32'h0000_0000, blk_lo_ff};
  // Window covers all 64 groups above the index position
  assign win_shift = {1'b0, index_pos} + GRP_SPAN;

  // Qualifiers built once per group; both sides share grp_en, egress alone uses egr_pass and ingress alone blk_hit
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g = g + 1) begin : g_grp
      // A group past the enabled count acts as if multicast were off
      assign grp_en[g] = mcast_en &&
        (g <= {26'h0, num_group});
      assign egr_pass[g] = grp_en[g] && egr_mask[g];
      assign blk_hit[g] = grp_en[g] && blk_mask[g];
    end
  endgenerate

  // Window test first; offsets past the span are not multicast
  assign eg_above_base = (i_vbus_addr >= base_addr);
  assign eg_off = i_vbus_addr - base_addr;
  assign eg_span = eg_off >> win_shift;
  assign eg_in_win = eg_above_base && (eg_span == 64'h0);
  assign eg_sh = eg_off >> index_pos;
  assign eg_grp = eg_sh[GRP_W-1:0];
  assign eg_mcast = eg_in_win && grp_en[eg_grp];
  // Traffic that is not multicast passes; multicast needs its mask bit
  assign eg_forward = !eg_mcast || egr_pass[eg_grp];
  assign nxt_egress_valid = i_vbus_valid && !i_vbus_from_this_port &&
                            eg_forward;

  // Ingress reuses the same window and group extraction
  assign in_above_base = (i_ingress_addr >= base_addr);
  assign in_off = i_ingress_addr - base_addr;
  assign in_span = in_off >> win_shift;
  assign in_in_win = in_above_base && (in_span == 64'h0);
  assign in_sh = in_off >> index_pos;
  assign in_grp = in_sh[GRP_W-1:0];
  assign in_mcast = in_in_win && grp_en[in_grp];
  // Only multicast of an enabled, blocked group is dropped
  assign nxt_ingress_drop = i_ingress_valid && in_mcast &&
                            blk_hit[in_grp];

  // Classifier results stand for exactly one cycle
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_egress_valid <= 1'b0;
    end else begin
      o_egress_valid <= nxt_egress_valid;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_egress_mcast <= 1'b0;
    end else begin
      o_egress_mcast <= eg_mcast;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_egress_addr <= 64'h0;
    end else begin
      o_egress_addr <= i_vbus_addr;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ingress_valid <= 1'b0;
    end else begin
      o_ingress_valid <= i_ingress_valid;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ingress_drop <= 1'b0;
    end else begin
      o_ingress_drop <= nxt_ingress_drop;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ingress_mcast <= 1'b0;
    end else begin
      o_ingress_mcast <= in_mcast;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ingress_group <= 6'h00;
    end else begin
      o_ingress_group <= in_grp;
    end
  end
endmodule // mpgf_filter

// [pkg/mpgf_consts.vh]
`ifndef MPGF_CONSTS_VH
`define MPGF_CONSTS_VH
`define MPGF_OFS_CTL 12'h336
`define MPGF_OFS_BASE_LO 12'h338
`define MPGF_OFS_BASE_HI 12'h33C
`define MPGF_OFS_EGR_LO 12'h340
`define MPGF_OFS_EGR_HI 12'h344
`define MPGF_OFS_BLK_LO 12'h348
`define MPGF_RST_WORD 32'h0000_0000
`define MPGF_RST_CTL 16'h0000
`define MPGF_CTL_EN_BIT 15
`define MPGF_FLD_LSB 0
`define MPGF_FLD_MSB 5
`define MPGF_BASE_LO_LSB 12
`endif

// [verif/mpgf_peer.sv]
module mpgf_peer(input wire logic i_clk, output logic o_valid, o_from,
  output logic [63:0] o_addr);
  timeunit 1ns; timeprecision 1ns;
  initial begin o_valid = 0; o_from = 0; o_addr = '1; end
  // Released lines flip so a stale value never looks valid
  task send(logic [63:0] a, logic f);
    @(posedge i_clk); o_valid <= 1; o_addr <= a; o_from <= f;
    @(posedge i_clk); o_valid <= 0; o_addr <= ~a; o_from <= ~f;
  endtask
endmodule // mpgf_peer

// [verif/mpgf_sva.sv]
`include "mpgf_consts.vh"
module mpgf_sva(input wire logic i_clk, i_sys_rst, i_reg_wr, i_reg_rd,
  i_vbus_valid, i_vbus_from_this_port, o_egress_valid, i_ingress_valid,
  o_ingress_valid, o_ingress_drop, o_ingress_mcast,
  input wire logic [11:0] i_reg_addr, input wire logic [31:0] i_reg_wdata,
  o_reg_rdata, input wire logic [63:0] i_vbus_addr, o_egress_addr);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  rd_idle_a:
  assert property (!$past(i_reg_rd) |-> o_reg_rdata == 0) else $error("rd");
  upper_rw_a:
  assert property (i_reg_wr && i_reg_addr == `MPGF_OFS_BASE_HI ##1 i_reg_rd &&
    i_reg_addr == `MPGF_OFS_BASE_HI |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("upper");
  no_echo_a:
  assert property (i_vbus_valid && i_vbus_from_this_port |=> !o_egress_valid)
    else $error("echo");
  egr_cause_a:
  assert property (o_egress_valid |-> $past(i_vbus_valid)) else $error("eg");
  egr_addr_a:
  assert property (o_egress_valid |-> o_egress_addr == $past(i_vbus_addr))
    else $error("eaddr");
  ing_lat_a:
  assert property (i_ingress_valid |=> o_ingress_valid) else $error("ing");
  ing_cause_a:
  assert property (o_ingress_valid |-> $past(i_ingress_valid)) else $error("ic");
  drop_mc_a:
  assert property (o_ingress_drop |-> o_ingress_valid && o_ingress_mcast)
    else $error("drop");
endmodule // mpgf_sva
bind mpgf_filter mpgf_sva chk(.*);

// [verif/tb_top.sv]
`include "mpgf_consts.vh"
module tb_top;
  timeunit 1ns; timeprecision 1ns;
  logic i_clk = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_vbus_valid;
  logic i_ingress_valid = 0, i_vbus_from_this_port, o_egress_valid;
  logic o_egress_mcast, o_ingress_valid, o_ingress_drop, o_ingress_mcast;
  logic [5:0] o_ingress_group; logic [11:0] i_reg_addr = 0;
  logic [31:0] i_reg_wdata = 0, o_reg_rdata;
  logic [63:0] i_ingress_addr = 0, i_vbus_addr, o_egress_addr;
  int mismatches = 0, samples_checked = 0;
  always #20 i_clk = ~i_clk;
  mpgf_filter uut(.*);
  mpgf_peer peer(.i_clk, .o_valid(i_vbus_valid), .o_from(i_vbus_from_this_port),
    .o_addr(i_vbus_addr));
  task chk(logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin mismatches++; $display("mismatch %0t %h", $time, s); end
  endtask
  function logic [63:0] adr(int g);
    return {32'h0000_0001, 32'h0010_0000 + g * 32'h1000};
  endfunction
  task wrrd(logic [11:0] a, logic [31:0] d, e);
    @(posedge i_clk); i_reg_wr <= 1; i_reg_addr <= a; i_reg_wdata <= d;
    @(posedge i_clk); i_reg_wr <= 0; i_reg_rd <= 1;
    @(posedge i_clk); i_reg_rd <= 0; #1 chk(o_reg_rdata, e);
  endtask
  task rd0(logic [11:0] a);
    @(posedge i_clk); i_reg_rd <= 1; i_reg_addr <= a;
    @(posedge i_clk); i_reg_rd <= 0; #1 chk(o_reg_rdata, 0);
  endtask
  task pkt(int g, logic f, v, m);
    peer.send(adr(g), f); #1 chk(o_egress_valid, v);
    if (v) chk(o_egress_mcast, m);
    if (v) chk(o_egress_addr, adr(g));
  endtask
  task ing(int g, logic dr, m);
    @(posedge i_clk); i_ingress_valid <= 1; i_ingress_addr <= adr(g);
    @(posedge i_clk); i_ingress_valid <= 0; i_ingress_addr <= ~adr(g);
    #1 chk(o_ingress_drop, dr);
    chk(o_ingress_valid, 1);
    chk(o_ingress_mcast, m);
    if (m) chk(o_ingress_group, g);
  endtask
  task s_setup; // 34 groups, 256 KiB window above 4 GiB
    wrrd(`MPGF_OFS_CTL, 32'h0000_8021, 32'h0000_8021);
    wrrd(`MPGF_OFS_BASE_LO, 32'h0010_000C, 32'h0010_000C);
    wrrd(`MPGF_OFS_BASE_HI, 32'h0000_0001, 32'h0000_0001);
    wrrd(`MPGF_OFS_EGR_LO, 32'h0000_0004, 32'h0000_0004);
    wrrd(`MPGF_OFS_EGR_HI, 32'h0000_0102, 32'h0000_0102);
    wrrd(`MPGF_OFS_BLK_LO, 32'h0000_0004, 32'h0000_0004);
    wrrd(12'h3F0, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask
  task s_egress;
    pkt(2, 0, 1, 1);
    pkt(2, 1, 0, 0);
    pkt(33, 0, 1, 1);
    pkt(3, 0, 0, 0);
    pkt(34, 0, 1, 0);
    pkt(40, 0, 1, 0);
    pkt(64, 0, 1, 0);
  endtask
  task s_ingress;
    ing(2, 1, 1);
    ing(3, 0, 1);
    wrrd(`MPGF_OFS_CTL, 32'h0000_0021, 32'h0000_0021);
    ing(2, 0, 0);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    rd0(`MPGF_OFS_BASE_HI);
    s_setup; s_egress; s_ingress; tally_and_finish;
  end
endmodule // tb_top
